// ### hdl/tws_device.sv
// Two-wire register slave: bus engine on the link clock, register port on clk
`timescale 1ns/10ps
module tws_device (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    tws_if.dev bus,
    input wire logic address_select_pin,
    output logic reg_wr,
    output logic reg_rd,
    output logic [tws_pkg::REG_W-1:0] reg_addr,
    output logic [tws_pkg::REG_W-1:0] reg_wdata,
    input wire logic [tws_pkg::REG_W-1:0] reg_rdata
);
    typedef enum logic [6:0] {
        TWS_IDLE = 7'h01,
        TWS_ADDR = 7'h02,
        TWS_RX = 7'h04,
        TWS_ACK = 7'h08,
        TWS_TX = 7'h10,
        TWS_RACK = 7'h20,
        TWS_IGNORE = 7'h40
    } tws_dev_state_e;

    tws_dev_state_e state;
    // Link-side bus tracking, shifter and pointer
    logic scl_s, sda_s, sel_s, scl_d, sda_d, rw, nack, lo_sel, sda_drv;
    logic [3:0] cnt;
    logic [1:0] bidx;
    logic [tws_pkg::BYTE_W-1:0] sr, wr_hi;
    logic [tws_pkg::REG_W-1:0] ptr, xfer_addr, xfer_data, rd_word;
    logic ovr_en, req_tgl, xfer_wr, ack_s, ack_d;
    logic [tws_pkg::SLV_W-1:0] ovr_addr;
    // Register-side state
    logic req_s, req_d, ack_tgl;
    logic [tws_pkg::REG_W-1:0] rd_hold;
    // Bus lines and strap enter the link domain through two flops
    tws_sync #(.W(3)) u_pin_sync (
        .clk(link_clk),
        .rst_b(rst_b),
        .d({bus.scl, bus.sda, address_select_pin}),
        .q({scl_s, sda_s, sel_s})
    );
    // Completion toggle back from the register side
    tws_sync #(.W(1)) u_ack_sync (
        .clk(link_clk),
        .rst_b(rst_b),
        .d(ack_tgl),
        .q(ack_s)
    );
    // Request toggle into the register side
    tws_sync #(.W(1)) u_req_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(req_tgl),
        .q(req_s)
    );

    // Bus events; SCL is only sampled, never driven here
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_ev = scl_s && scl_d && sda_d && !sda_s;
    wire stop_ev = scl_s && scl_d && !sda_d && sda_s;
    wire byte_done = scl_fall && (cnt == tws_pkg::BYTE_CNT);
    wire [tws_pkg::SLV_W-1:0] strap_addr = sel_s ? tws_pkg::ADDR_ALT : tws_pkg::ADDR_DEFAULT;
    wire [tws_pkg::SLV_W-1:0] act_addr = ovr_en ? ovr_addr : strap_addr;
    wire addr_hit = (sr[tws_pkg::BYTE_W-1:1] == act_addr);
    wire [tws_pkg::REG_W-1:0] wr_word = {wr_hi, sr};
    wire [tws_pkg::REG_W-1:0] ptr_next = ptr + 16'h0001;
    wire [tws_pkg::BYTE_W-1:0] rd_hi = rd_word[tws_pkg::REG_W-1:tws_pkg::BYTE_W];
    wire [tws_pkg::BYTE_W-1:0] rd_lo = rd_word[tws_pkg::BYTE_W-1:0];

    // Open-drain data: only ever pulls low
    assign bus.d_sda_o = 1'h0;
    assign bus.d_sda_oe = sda_drv;

    // Link-side protocol engine; sda_drv only changes on SCL falls or bus events
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= TWS_IDLE;
            scl_d <= 1'h0;
            sda_d <= 1'h0;
            cnt <= 4'h0;
            sr <= 8'h00;
            rw <= tws_pkg::DIR_WRITE;
            nack <= 1'h0;
            bidx <= 2'h0;
            lo_sel <= 1'h0;
            sda_drv <= 1'h0;
            ptr <= 16'h0000;
            wr_hi <= 8'h00;
            ovr_en <= 1'h0;
            ovr_addr <= 7'h00;
            req_tgl <= 1'h0;
            xfer_wr <= 1'h0;
            xfer_addr <= 16'h0000;
            xfer_data <= 16'h0000;
            ack_d <= 1'h0;
            rd_word <= 16'h0000;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            ack_d <= ack_s;
            // Read word handed back once its completion toggle has arrived
            if (ack_s != ack_d) begin
                rd_word <= rd_hold;
            end
            if (start_ev) begin
                // Fresh or repeated start both restart the byte sequence
                state <= TWS_ADDR;
                cnt <= 4'h0;
                bidx <= 2'h0;
                sda_drv <= 1'h0;
            end else if (stop_ev) begin
                state <= TWS_IDLE;
                sda_drv <= 1'h0;
            end else begin
                case (state)
                    TWS_ADDR, TWS_RX: begin
                        if (scl_rise) begin
                            sr <= {sr[tws_pkg::BYTE_W-2:0], sda_s};
                            cnt <= cnt + 4'h1;
                        end else if (byte_done && state == TWS_ADDR) begin
                            if (addr_hit) begin
                                state <= TWS_ACK;
                                sda_drv <= 1'h1;
                                rw <= sr[0];
                                if (sr[0] == tws_pkg::DIR_READ) begin
                                    // Fetch the word at the current pointer
                                    req_tgl <= !req_tgl;
                                    xfer_wr <= 1'h0;
                                    xfer_addr <= ptr;
                                end
                            end else begin
                                state <= TWS_IGNORE;
                            end
                        end else if (byte_done) begin
                            state <= TWS_ACK;
                            sda_drv <= 1'h1;
                            bidx <= bidx + 2'h1;
                            case (bidx)
                                2'h0: ptr[tws_pkg::REG_W-1:tws_pkg::BYTE_W] <= sr;
                                2'h1: ptr[tws_pkg::BYTE_W-1:0] <= sr;
                                2'h2: wr_hi <= sr;
                                default: begin
                                    // Second data byte completes a word
                                    req_tgl <= !req_tgl;
                                    xfer_wr <= 1'h1;
                                    xfer_addr <= ptr;
                                    xfer_data <= wr_word;
                                    ptr <= ptr_next;
                                    bidx <= 2'h2;
                                    if (ptr == tws_pkg::REG_SLAVE_ADDR) begin
                                        ovr_en <= sr[tws_pkg::OVR_EN_BIT];
                                        ovr_addr <= sr[tws_pkg::OVR_ADDR_MSB:tws_pkg::OVR_ADDR_LSB];
                                    end
                                end
                            endcase
                        end
                    end
                    TWS_ACK: begin
                        if (scl_fall) begin
                            cnt <= 4'h0;
                            if (rw == tws_pkg::DIR_READ) begin
                                state <= TWS_TX;
                                sr <= rd_hi;
                                sda_drv <= !rd_hi[tws_pkg::BYTE_W-1];
                                lo_sel <= 1'h0;
                            end else begin
                                state <= TWS_RX;
                                sda_drv <= 1'h0;
                            end
                        end
                    end
                    TWS_TX: begin
                        if (scl_rise) begin
                            cnt <= cnt + 4'h1;
                        end else if (byte_done) begin
                            // Let go of data so the master can answer
                            sda_drv <= 1'h0;
                            state <= TWS_RACK;
                        end else if (scl_fall) begin
                            sr <= {sr[tws_pkg::BYTE_W-2:0], 1'h0};
                            sda_drv <= !sr[tws_pkg::BYTE_W-2];
                        end
                    end
                    TWS_RACK: begin
                        if (scl_rise) begin
                            nack <= sda_s;
                        end else if (scl_fall && nack) begin
                            state <= TWS_IGNORE;
                        end else if (scl_fall) begin
                            state <= TWS_TX;
                            cnt <= 4'h0;
                            lo_sel <= !lo_sel;
                            if (!lo_sel) begin
                                sr <= rd_lo;
                                sda_drv <= !rd_lo[tws_pkg::BYTE_W-1];
                                // High byte acknowledged: load the low byte, advance and prefetch the next one
                                ptr <= ptr_next;
                                req_tgl <= !req_tgl;
                                xfer_wr <= 1'h0;
                                xfer_addr <= ptr_next;
                            end else begin
                                sr <= rd_hi;
                                sda_drv <= !rd_hi[tws_pkg::BYTE_W-1];
                            end
                        end
                    end
                    TWS_IDLE, TWS_IGNORE: sda_drv <= 1'h0;
                    default: begin
                        state <= TWS_IDLE;
                        sda_drv <= 1'h0;
                    end
                endcase
            end
        end
    end

    // Register side: transfer words are held steady until the toggle is seen
    wire req_new = (req_s != req_d);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_d <= 1'h0;
            reg_wr <= 1'h0;
            reg_rd <= 1'h0;
            reg_addr <= 16'h0000;
            reg_wdata <= 16'h0000;
            rd_hold <= 16'h0000;
            ack_tgl <= 1'h0;
        end else begin
            req_d <= req_s;
            reg_wr <= req_new && xfer_wr;
            reg_rd <= req_new && !xfer_wr;
            if (req_new) begin
                reg_addr <= xfer_addr;
                reg_wdata <= xfer_data;
            end
            if (reg_rd) begin
                rd_hold <= reg_rdata;
            end
            if (reg_wr || reg_rd) begin
                ack_tgl <= !ack_tgl;
            end
        end
    end
endmodule

// ### hdl/tws_pkg.sv
// Shared constants for the two-wire register slave and its bus master
package tws_pkg;
    localparam int REG_W = 16;
    localparam int SLV_W = 7;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BYTE_CNT = 4'h8;
    // Seven-bit addresses; the bus bytes are 0x90/0x91 and 0xba/0xbb
    localparam logic [6:0] ADDR_DEFAULT = 7'h48;
    localparam logic [6:0] ADDR_ALT = 7'h5d;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    // Register that replaces the strap-selected slave address
    localparam logic [15:0] REG_SLAVE_ADDR = 16'hfff0;
    localparam int OVR_EN_BIT = 0;
    localparam int OVR_ADDR_LSB = 1;
    localparam int OVR_ADDR_MSB = 7;
    // Bus master timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage

// ### hdl/tws_if.sv
// Open-drain two-wire bus joining the bus master and the register slave
`timescale 1ns/10ps
interface tws_if;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Pull-ups hold both lines high unless an enabled driver pulls low
    assign scl = !(h_scl_oe && !h_scl_o);
    assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

    modport host (output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe, input sda);
    modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// ### hdl/tws_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module tws_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### hdl/tws_host.sv
// Two-wire bus master: single-word register writes and reads
`timescale 1ns/10ps
module tws_host #(
    parameter int QUARTER = tws_pkg::QUARTER_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    tws_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic cmd_current,
    input wire logic [tws_pkg::SLV_W-1:0] cmd_slave,
    input wire logic [tws_pkg::REG_W-1:0] cmd_reg,
    input wire logic [tws_pkg::REG_W-1:0] cmd_wdata,
    output logic rsp_valid,
    output logic rsp_nack,
    output logic [tws_pkg::REG_W-1:0] rsp_rdata
);
    typedef enum logic [1:0] {
        TWH_IDLE = 2'h1,
        TWH_RUN = 2'h2
    } tws_host_state_e;

    typedef enum logic [5:0] {
        OP_STA = 6'h01,
        OP_TX = 6'h02,
        OP_RXA = 6'h04,
        OP_RXN = 6'h08,
        OP_STO = 6'h10,
        OP_END = 6'h20
    } tws_op_e;

    // Program steps; a current-location read enters the read program mid-way
    localparam logic [3:0] STEP_CUR = 4'h4;
    localparam logic [3:0] STEP_STO_WR = 4'h6;
    localparam logic [3:0] STEP_STO_RD = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [1:0] Q_LAST = 2'h3;

    tws_host_state_e state;
    logic [15:0] div;
    logic [1:0] q;
    logic [3:0] step;
    logic [3:0] bitn;
    logic [tws_pkg::BYTE_W-1:0] sr;
    logic [tws_pkg::REG_W-1:0] rx;
    logic c_read;
    logic [tws_pkg::SLV_W-1:0] c_slave;
    logic [tws_pkg::REG_W-1:0] c_reg;
    logic [tws_pkg::REG_W-1:0] c_wdata;
    logic nack_seen;
    logic scl_low;
    logic sda_low;
    logic sda_s;

    // Sequence of bus elements for a write or a random read
    function automatic tws_op_e op_of(input logic [3:0] s, input logic rd);
        if (rd) begin
            case (s)
                4'h0, 4'h4: op_of = OP_STA;
                4'h1, 4'h2, 4'h3, 4'h5: op_of = OP_TX;
                4'h6: op_of = OP_RXA;
                4'h7: op_of = OP_RXN;
                4'h8: op_of = OP_STO;
                default: op_of = OP_END;
            endcase
        end else begin
            case (s)
                4'h0: op_of = OP_STA;
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5: op_of = OP_TX;
                4'h6: op_of = OP_STO;
                default: op_of = OP_END;
            endcase
        end
    endfunction

    // Byte sent at each transmit step, register address high byte first
    function automatic logic [7:0] byte_of(input logic [3:0] s, input logic rd, input logic [6:0] slv,
                                           input logic [15:0] ra, input logic [15:0] wd);
        case (s)
            4'h1: byte_of = {slv, tws_pkg::DIR_WRITE};
            4'h2: byte_of = ra[15:8];
            4'h3: byte_of = ra[7:0];
            4'h4: byte_of = wd[15:8];
            4'h5: byte_of = rd ? {slv, tws_pkg::DIR_READ} : wd[7:0];
            default: byte_of = 8'h00;
        endcase
    endfunction

    tws_sync #(.W(1)) u_sda_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(bus.sda),
        .q(sda_s)
    );

    // Slot decode; a bit slot holds SCL low for two quarters then high for two
    tws_op_e op;
    assign op = op_of(step, c_read);
    wire tick = (div == 16'(QUARTER - 1));
    wire slot_end = tick && (q == Q_LAST);
    wire is_bit = (op == OP_TX) || (op == OP_RXA) || (op == OP_RXN);
    wire bit_is_ack = (bitn == BIT_ACK);
    wire tx_low = (op == OP_TX) && !bit_is_ack && !sr[tws_pkg::BYTE_W-1];
    wire rx_low = (op == OP_RXA) && bit_is_ack;
    wire [3:0] step_inc = step + 4'h1;
    wire [3:0] stop_step = c_read ? STEP_STO_RD : STEP_STO_WR;
    wire next_scl_low = (state == TWH_RUN) && (is_bit ? (q <= 2'h1) : (op != OP_END) && (q == 2'h0));
    wire next_sda_low = (state == TWH_RUN) && ((op == OP_STA) ? (q >= 2'h2) :
                        (op == OP_STO) ? (q <= 2'h1) : (tx_low || rx_low));

    assign cmd_ready = (state == TWH_IDLE);
    assign bus.h_scl_o = 1'h0;
    assign bus.h_scl_oe = scl_low;
    assign bus.h_sda_o = 1'h0;
    assign bus.h_sda_oe = sda_low;

    // Quarter-period divider and output drives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div <= 16'h0000;
            scl_low <= 1'h0;
            sda_low <= 1'h0;
        end else begin
            div <= (tick || state == TWH_IDLE) ? 16'h0000 : div + 16'h0001;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
        end
    end

    // Step sequencer; data sampled at the end of each high phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= TWH_IDLE;
            q <= 2'h0;
            step <= 4'h0;
            bitn <= 4'h0;
            sr <= 8'h00;
            rx <= 16'h0000;
            c_read <= 1'h0;
            c_slave <= 7'h00;
            c_reg <= 16'h0000;
            c_wdata <= 16'h0000;
            nack_seen <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_nack <= 1'h0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= 1'h0;
            if (state == TWH_IDLE && cmd_valid) begin
                state <= TWH_RUN;
                c_read <= cmd_read;
                c_slave <= cmd_slave;
                c_reg <= cmd_reg;
                c_wdata <= cmd_wdata;
                step <= (cmd_read && cmd_current) ? STEP_CUR : 4'h0;
                q <= 2'h0;
                bitn <= 4'h0;
                nack_seen <= 1'h0;
            end else if (state == TWH_RUN && op == OP_END) begin
                state <= TWH_IDLE;
                rsp_valid <= 1'h1;
                rsp_nack <= nack_seen;
                rsp_rdata <= rx;
            end else if (state == TWH_RUN && tick) begin
                q <= q + 2'h1;
                if (slot_end && is_bit && !bit_is_ack) begin
                    bitn <= bitn + 4'h1;
                    sr <= {sr[tws_pkg::BYTE_W-2:0], 1'h0};
                    if (op != OP_TX) begin
                        rx <= {rx[tws_pkg::REG_W-2:0], sda_s};
                    end
                end else if (slot_end && is_bit && op == OP_TX && sda_s) begin
                    nack_seen <= 1'h1;
                    bitn <= 4'h0;
                    step <= stop_step;
                end else if (slot_end) begin
                    bitn <= 4'h0;
                    step <= step_inc;
                    sr <= byte_of(step_inc, c_read, c_slave, c_reg, c_wdata);
                end
            end
        end
    end
endmodule

// ### dv/tws_props.sv
// Wire-level checks on the two-wire bus between master and slave
`timescale 1ns/10ps
module tws_props (
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic h_scl_oe,
    input wire logic h_sda_oe,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    // Bus events from the sampled lines; no sampled functions outside properties
    wire start_ev = scl && scl_q && sda_q && !sda;
    wire stop_ev = scl && scl_q && !sda_q && sda;
    wire rise_ev = scl && !scl_q;
    wire ack_slot = rise_ev && (bit_cnt == 4'h8);
    wire [3:0] next_bit_cnt = (start_ev || stop_ev || ack_slot) ? 4'h0 : bit_cnt + {3'h0, rise_ev};
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rst_b);
    // Clock rises since the last start or stop, wrapping after the ninth
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            bit_cnt <= next_bit_cnt;
        end
    end
    AST_DEV_EDGE: assert property ($changed(d_sda_oe) |-> !scl && !scl_q)
        else $error("slave moved data while clock high");
    AST_HOST_START: assert property (start_ev |-> h_sda_oe && !d_sda_oe)
        else $error("start not made by master");
    AST_ONE_TX: assert property (scl |-> !(h_sda_oe && d_sda_oe))
        else $error("both ends drive data while clock high");
    AST_ACK_HOLD: assert property (ack_slot && d_sda_oe |-> d_sda_oe [*8])
        else $error("slave ack not held through clock high");
    AST_NACK_RELEASE: assert property (ack_slot && sda |=> !d_sda_oe [*8])
        else $error("slave drives after no-acknowledge");
    AST_DEV_BIT_HOLD: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
        else $error("slave bit shorter than a clock phase");
    AST_STOP_IDLE: assert property (stop_ev |-> (scl && sda) [*8])
        else $error("bus not idle after stop");
    AST_IDLE_RELEASED: assert property (stop_ev |-> !d_sda_oe && !h_sda_oe && !h_scl_oe)
        else $error("a driver still enabled on idle bus");
    AST_DEV_RISE_LOW: assert property ($rose(d_sda_oe) |-> !h_sda_oe)
        else $error("slave drives while master transmits");
    // Main scenarios: slave ack, master ack, no-ack, restart
    cover property (ack_slot && d_sda_oe);
    cover property (ack_slot && h_sda_oe);
    cover property (ack_slot && sda);
    cover property (start_ev && bit_cnt != 4'h0);
endmodule

// ### dv/tb_top.sv
// Self-checking bench: master and slave joined over the two-wire bus
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic address_select_pin = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic cmd_read = 1'b0;
    logic cmd_current = 1'b0;
    logic [6:0] cmd_slave = 7'h00;
    logic [15:0] cmd_reg = 16'h0000;
    logic [15:0] cmd_wdata = 16'h0000;
    logic rsp_valid;
    logic rsp_nack;
    logic [15:0] rsp_rdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] last_wa = 16'h0000;
    logic [15:0] last_wd = 16'h0000;
    wire [15:0] reg_rdata;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int errors = 0;
    int checked = 0;
    tws_if bus ();
    // Register file stand-in: read data is a scramble of the address
    assign reg_rdata = reg_addr ^ 16'h3c5a;
    initial forever #12.5 clk = ~clk;
    // Link clock offset so it never lines up with clk
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    tws_host #(.QUARTER(8)) tws_host_inst (.clk(clk), .rst_b(rst_b), .bus(bus.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_current(cmd_current), .cmd_slave(cmd_slave),
        .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
    tws_device tws_device_inst (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .bus(bus.dev),
        .address_select_pin(address_select_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    tws_props tws_props_inst (.link_clk(link_clk), .rst_b(rst_b), .h_scl_oe(bus.h_scl_oe),
        .h_sda_oe(bus.h_sda_oe), .d_sda_oe(bus.d_sda_oe), .scl(bus.scl), .sda(bus.sda));
    // Record every register write and count the reads the slave issues
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (reg_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wa <= reg_addr;
            last_wd <= reg_wdata;
        end
    end
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    // One command, held until taken, then wait for the response pulse
    task automatic do_cmd(input logic rd, input logic cur, input logic [6:0] slv, input logic [15:0] ra,
        input logic [15:0] wd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_current = cur;
        cmd_slave = slv;
        cmd_reg = ra;
        cmd_wdata = wd;
        // Ready is settled between edges, so the next rising edge takes it
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge clk);
    endtask
    task automatic t_basic();
        int base;
        int rbase;
        base = wr_cnt;
        do_cmd(1'b0, 1'b0, tws_pkg::ADDR_DEFAULT, 16'h0003, 16'ha55a);
        chk_bit(rsp_nack, 1'b0, "write refused");
        chk_word(16'(wr_cnt - base), 16'h0001, "write count");
        chk_word(last_wa, 16'h0003, "write address");
        chk_word(last_wd, 16'ha55a, "write data");
        rbase = rd_cnt;
        do_cmd(1'b1, 1'b0, tws_pkg::ADDR_DEFAULT, 16'h0005, 16'h0000);
        chk_word(rsp_rdata, 16'h0005 ^ 16'h3c5a, "random read");
        chk_word(16'(rd_cnt - rbase), 16'h0002, "word fetches");
        do_cmd(1'b1, 1'b1, tws_pkg::ADDR_DEFAULT, 16'h0000, 16'h0000);
        chk_word(rsp_rdata, 16'h0006 ^ 16'h3c5a, "current read");
    endtask
    task automatic t_strap();
        int base;
        base = wr_cnt;
        do_cmd(1'b0, 1'b0, tws_pkg::ADDR_ALT, 16'h0010, 16'h1234);
        chk_bit(rsp_nack, 1'b1, "other address taken");
        chk_word(16'(wr_cnt - base), 16'h0000, "ignored write");
        address_select_pin = 1'b1;
        repeat (4) @(negedge clk);
        do_cmd(1'b0, 1'b0, tws_pkg::ADDR_ALT, 16'h0010, 16'h1234);
        chk_bit(rsp_nack, 1'b0, "strap address refused");
        chk_word(last_wd, 16'h1234, "strap write data");
    endtask
    // Override replaces the strap address, which is then refused
    task automatic t_override();
        do_cmd(1'b0, 1'b0, tws_pkg::ADDR_ALT, tws_pkg::REG_SLAVE_ADDR, {8'h00, 7'h22, 1'b1});
        do_cmd(1'b0, 1'b0, 7'h22, 16'h0020, 16'hbeef);
        chk_bit(rsp_nack, 1'b0, "new address refused");
        chk_word(last_wa, 16'h0020, "new address write");
        do_cmd(1'b1, 1'b0, tws_pkg::ADDR_ALT, 16'h0020, 16'h0000);
        chk_bit(rsp_nack, 1'b1, "old address taken");
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        t_basic();
        t_strap();
        t_override();
        end_of_test();
    end
    // Watchdog: some five times the expected run of eight commands
    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
